// File: hw/ust_map.svh
// register map, field positions, reset values and timing constants for the threshold block
// Overview of operation
// RULE_01: eight-bit writable frame threshold count, resets zero
// RULE_02: software sizes threshold to largest packet length
// RULE_03: upper bits of both registers read zero
// RULE_04: seven-bit field gives table address bits 15-9
// RULE_05: table base is 512-byte aligned, low bits zero
// RULE_06: page register bit zero reads zero
// RULE_07: module runs only from 48 MHz clock; the frame timing constants here assume a 25 MHz core clock
// RULE_08: pll reference input must be 4 MHz
// RULE_09: disabled module releases data, id, power pins
// RULE_10: host withholds tokens when frame time short
`ifndef UST_MAP_SVH
`define UST_MAP_SVH
`define UST_OFF_SOF_THR     8'h00
`define UST_OFF_BDT_PAGE    8'h04
`define UST_OFF_CTRL        8'h08
`define UST_OFF_STATUS      8'h0C
`define UST_THR_RST         8'h00
`define UST_PAGE_RST        7'h00
`define UST_PAGE_LSB        1
`define UST_PAGE_MSB        7
`define UST_BASE_LSB        9
`define UST_CTRL_EN_BIT     0
`define UST_CTRL_HOST_BIT   1
`define UST_CTRL_CLKOK_BIT  2
`define UST_CLK_MHZ         25
// one byte time of a 1500-byte frame; truncated to whole cycles, so a frame runs slightly short
`define UST_BYTE_NS         670
`define UST_BYTE_CYC        ((`UST_BYTE_NS * `UST_CLK_MHZ) / 1000)
`define UST_FRAME_BYTES     14'h05DC
`endif

// File: hw/ust_pkg.sv
// types shared by the threshold block
package ust_pkg;
    typedef enum logic [1:0] {UST_IDLE, UST_WAIT, UST_BUSY} ust_tok_e;
endpackage : ust_pkg

// File: hw/ust_frame_cnt.sv
// frame byte-time counter: bytes left before the next start-of-frame
`timescale 1ns/1ps
`default_nettype none
`include "ust_map.svh"
module ust_frame_cnt
    import ust_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    output logic [13:0]      bytes_left_q,
    output logic             sof_q
);
    logic [7:0] div_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else if (!run || div_q == 8'(`UST_BYTE_CYC - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bytes_left_q <= `UST_FRAME_BYTES;
            sof_q        <= 1'b0;
        end else begin
            sof_q <= 1'b0;
            if (!run) begin
                bytes_left_q <= `UST_FRAME_BYTES;
            end else if (div_q == 8'(`UST_BYTE_CYC - 1)) begin
                if (bytes_left_q == 14'h0001) begin
                    bytes_left_q <= `UST_FRAME_BYTES;
                    sof_q        <= 1'b1;
                end else begin
                    bytes_left_q <= bytes_left_q - 14'h0001;
                end
            end
        end
    end
endmodule : ust_frame_cnt
`default_nettype wire

// File: hw/ust_top.sv
// frame threshold and descriptor table page registers with token gate and pin release
`timescale 1ns/1ps
`default_nettype none
`include "ust_map.svh"
module ust_top
    import ust_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tok_req,
    output logic             tok_start,
    input  wire logic        tok_done,
    output logic [31:0]      bdt_base,
    input  wire logic        usb_dp_out,
    input  wire logic        usb_dp_oe_n,
    input  wire logic        usb_dm_out,
    input  wire logic        usb_dm_oe_n,
    input  wire logic        usb_id_out,
    input  wire logic        usb_id_oe_n,
    input  wire logic        bus_power_control_out,
    input  wire logic [3:0]  gpio_out,
    input  wire logic [3:0]  gpio_oe_n,
    output logic [3:0]       pin_out,
    output logic [3:0]       pin_oe_n
);
    logic [7:0]  frame_threshold_count_q;
    logic [6:0]  descriptor_base_mid_bits_q;
    logic [2:0]  ctrl_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [13:0] bytes_left_q;
    logic        sof_q;
    logic        usb_on;
    logic        short_frame;
    ust_tok_e    tok_q;
    wire logic   acc = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic   wr  = acc && wb_we_i && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_threshold_count_q    <= `UST_THR_RST;              // see RULE_01
            descriptor_base_mid_bits_q <= `UST_PAGE_RST;             // see RULE_04
            ctrl_q                     <= 3'h0;
        end else if (wr) begin
            if (wb_adr_i == `UST_OFF_SOF_THR) begin
                frame_threshold_count_q <= wb_dat_i[7:0];            // see RULE_01
            end else if (wb_adr_i == `UST_OFF_BDT_PAGE) begin
                descriptor_base_mid_bits_q <=
                    wb_dat_i[`UST_PAGE_MSB:`UST_PAGE_LSB];           // see RULE_04
            end else if (wb_adr_i == `UST_OFF_CTRL) begin
                ctrl_q <= wb_dat_i[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data and ack; unmapped reads return zero, writes are dropped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc) begin
                if (wb_adr_i == `UST_OFF_SOF_THR) begin
                    rdat_q <= {24'h00_0000, frame_threshold_count_q};  // see RULE_03
                end else if (wb_adr_i == `UST_OFF_BDT_PAGE) begin
                    rdat_q <= {24'h00_0000, descriptor_base_mid_bits_q, 1'b0}; // see RULE_06
                end else if (wb_adr_i == `UST_OFF_CTRL) begin
                    rdat_q <= {29'h0000_0000, ctrl_q};
                end else if (wb_adr_i == `UST_OFF_STATUS) begin
                    rdat_q <= {16'h0000, short_frame, tok_q == UST_BUSY, bytes_left_q};
                end else begin
                    rdat_q <= 32'h0000_0000;
                end
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // table base: only bits 15-9 programmable, 512-byte aligned
    assign bdt_base = {16'h0000, descriptor_base_mid_bits_q, 9'h000};  // see RULE_05

    ////////////////////////////////////////////////////////////////////////////////
    // the core may only run when software vouches for the 48 MHz clock
    assign usb_on = ctrl_q[`UST_CTRL_EN_BIT] && ctrl_q[`UST_CTRL_CLKOK_BIT]; // see RULE_07

    ust_frame_cnt u_frame (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .run          (usb_on),
        .bytes_left_q (bytes_left_q),
        .sof_q        (sof_q)
    );

    // gate compares against a whole byte count, so a threshold of zero never blocks
    assign short_frame = bytes_left_q < {6'h00, frame_threshold_count_q};

    ////////////////////////////////////////////////////////////////////////////////
    // token gate in host role
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tok_q <= UST_IDLE;
        end else begin
            case (tok_q)
                UST_IDLE: begin
                    if (usb_on && ctrl_q[`UST_CTRL_HOST_BIT] && tok_req) begin
                        tok_q <= short_frame ? UST_WAIT : UST_BUSY;   // see RULE_10
                    end
                end
                UST_WAIT: begin
                    if (!usb_on) begin
                        tok_q <= UST_IDLE;
                    end else if (sof_q) begin
                        tok_q <= UST_IDLE;
                    end
                end
                UST_BUSY: begin
                    if (tok_done || !usb_on) begin
                        tok_q <= UST_IDLE;
                    end
                end
                default: tok_q <= UST_IDLE;
            endcase
        end
    end
    assign tok_start = (tok_q == UST_IDLE) && usb_on && ctrl_q[`UST_CTRL_HOST_BIT]
                       && tok_req && !short_frame;                  // see RULE_10

    ////////////////////////////////////////////////////////////////////////////////
    // pin ownership: 0 d+, 1 d-, 2 id, 3 bus power
    always_comb begin
        if (usb_on) begin
            pin_out  = {bus_power_control_out, usb_id_out, usb_dm_out, usb_dp_out};
            pin_oe_n = {1'b0, usb_id_oe_n, usb_dm_oe_n, usb_dp_oe_n};
        end else begin
            pin_out  = gpio_out;                                     // see RULE_09
            pin_oe_n = gpio_oe_n;                                    // see RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_thr_write: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_01
        wr && wb_adr_i == `UST_OFF_SOF_THR |=> frame_threshold_count_q == $past(wb_dat_i[7:0]))
        else $error("threshold write lost");
    a_thr_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_03
        $past(acc) && $past(wb_adr_i) == `UST_OFF_SOF_THR |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("threshold upper bits not zero");
    a_page_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_03
        $past(acc) && $past(wb_adr_i) == `UST_OFF_BDT_PAGE |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("page upper bits not zero");
    a_page_write: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_04
        wr && wb_adr_i == `UST_OFF_BDT_PAGE |=> bdt_base[15:9] == $past(wb_dat_i[7:1]))
        else $error("table base bits wrong");
    a_base_align: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_05
        bdt_base[8:0] == 9'h000 && bdt_base[31:16] == 16'h0000)
        else $error("table base not aligned");
    a_page_bit0: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_06
        $past(acc) && $past(wb_adr_i) == `UST_OFF_BDT_PAGE |-> !wb_dat_o[0])
        else $error("page bit zero set");
    a_clk_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_07
        !ctrl_q[`UST_CTRL_CLKOK_BIT] |-> !tok_start && pin_oe_n == gpio_oe_n)
        else $error("running without clock");
    a_pin_release: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_09
        !usb_on |-> pin_out == gpio_out && pin_oe_n == gpio_oe_n)
        else $error("pins not released");
    a_tok_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        short_frame |-> !tok_start)
        else $error("token started in short frame");
    a_ack_one: assert property (@(posedge core_clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    ////////////////////////////////////////////////////////////////////////////////
    // token gate steps: an ask in a short frame parks, a frame start frees it
    sequence s_host_ask;
        tok_q == UST_IDLE && usb_on && ctrl_q[`UST_CTRL_HOST_BIT] && tok_req;
    endsequence
    sequence s_parked;
        tok_q == UST_WAIT && usb_on;
    endsequence
    a_tok_park: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        s_host_ask ##0 short_frame |=> tok_q == UST_WAIT)
        else $error("short frame ask not parked");
    a_tok_grant: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        s_host_ask ##0 !short_frame |-> tok_start ##1 tok_q == UST_BUSY)
        else $error("open frame ask not granted");
    a_wait_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        s_parked ##0 !sof_q |=> tok_q == UST_WAIT && !tok_start)
        else $error("parked token left early");
    a_wait_leave: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_10
        s_parked ##0 sof_q |=> tok_q == UST_IDLE)
        else $error("parked token missed frame start");
    a_busy_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        tok_q == UST_BUSY && tok_done |=> tok_q == UST_IDLE)
        else $error("token not ended");
    a_power_drive: assert property (@(posedge core_clk) disable iff (!rst_n) // see RULE_09
        usb_on |-> !pin_oe_n[3] && pin_out[3] == bus_power_control_out)
        else $error("bus power pin not driven");
    a_status_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(acc) && $past(wb_adr_i) == `UST_OFF_STATUS |->
            wb_dat_o[31:16] == 16'h0000 && wb_dat_o[13:0] == $past(bytes_left_q))
        else $error("status read wrong");
    a_sof_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
        sof_q |-> bytes_left_q == `UST_FRAME_BYTES)
        else $error("frame count not restarted");
endmodule : ust_top
`default_nettype wire

// File: test/ust_peer_model.sv
// host core model that asks for token slots and ends each token
`timescale 1ns/1ps
`default_nettype none
module ust_peer_model
    import ust_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic want,
    input  wire logic tok_start,
    output logic      tok_req,
    output logic      tok_done
);
    logic [2:0] busy_q;
    ////////////////////////////////////////////////////////////////////////////////
    // the request is held until granted: the core never forces a token past the gate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tok_req  <= 1'b0;
            tok_done <= 1'b0;
            busy_q   <= 3'h0;
        end else begin
            tok_done <= (busy_q == 3'h1);
            if (busy_q != 3'h0) begin
                busy_q <= busy_q - 3'h1;
            end
            if (tok_req && tok_start) begin
                tok_req <= 1'b0;
                busy_q  <= 3'h5;
            end else if (want && !tok_req && busy_q == 3'h0 && !tok_done) begin
                tok_req <= 1'b1;
            end
        end
    end
endmodule : ust_peer_model
`default_nettype wire

// File: test/usb_sof_threshold_bdt_base_tb.sv
// bench for the frame threshold and descriptor page registers
`timescale 1ns/1ps
`default_nettype none
`include "ust_map.svh"
module usb_sof_threshold_bdt_base_tb;
    import ust_pkg::*;
    logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, want, tok_req, tok_start;
    logic tok_done;
    logic        usb_dp_out, usb_dm_out;
    logic [3:0]  gpio_out, gpio_oe_n;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, pin_out, pin_oe_n, c;
    logic [31:0] wb_dat_i, wb_dat_o, bdt_base, d;
    logic [7:0]  codes [4] = '{8'h4A, 8'h2A, 8'h1A, 8'h12};
    int          mismatches, num_checks, cycles, i;
    ust_top i_ust_top (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tok_req(tok_req),
        .tok_start(tok_start), .tok_done(tok_done), .bdt_base(bdt_base),
        .usb_dp_out(usb_dp_out), .usb_dp_oe_n(1'b0), .usb_dm_out(usb_dm_out), .usb_dm_oe_n(1'b1),
        .usb_id_out(1'b1), .usb_id_oe_n(1'b0), .bus_power_control_out(1'b1),
        .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    ust_peer_model i_ust_peer_model (.core_clk(core_clk), .rst_n(rst_n), .want(want),
        .tok_start(tok_start), .tok_req(tok_req), .tok_done(tok_done));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // entered just after an edge; one idle cycle follows so requests never merge
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        input logic [3:0] sel, output logic [31:0] rdat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    endtask : xfer
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        xfer(1'b1, adr, dat, sel, r);
    endtask : wr
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, adr, 32'h0, 4'hF, r);
        chk(r, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        // one frame is about 24000 cycles; the tail test waits through most of one
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, want} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        {usb_dp_out, usb_dm_out} = 2'h2;
        gpio_out = 4'h2;
        gpio_oe_n = 4'hD;
        d = 32'h0;
        rst_n = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`UST_OFF_SOF_THR, 32'h0);
        rd(`UST_OFF_BDT_PAGE, 32'h0);
        chk(bdt_base, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(`UST_OFF_SOF_THR, 32'hFFFFFF00 | codes[i], 4'hF);
            rd(`UST_OFF_SOF_THR, {24'h0, codes[i]});
        end
        wr(`UST_OFF_SOF_THR, 32'h33, 4'hE);
        rd(`UST_OFF_SOF_THR, 32'h12);
        wr(`UST_OFF_BDT_PAGE, 32'hFFFFFFFF, 4'hF);
        rd(`UST_OFF_BDT_PAGE, 32'hFE);
        chk(bdt_base, 32'hFE00);
        wr(`UST_OFF_BDT_PAGE, 32'h55, 4'hF);
        rd(`UST_OFF_BDT_PAGE, 32'h54);
        chk(bdt_base, 32'h5400);
        wr(8'h10, 32'hFFFFFFFF, 4'hF);
        rd(8'h10, 32'h0);
        // module counts as on only with enable and the clock-ready flag both set
        for (c = 4'h0; c < 4'h8; c++) begin
            gpio_out   <= 4'h2 ^ c;
            gpio_oe_n  <= 4'hD ^ c;
            usb_dp_out <= ~c[1];
            usb_dm_out <= c[1];
            wr(`UST_OFF_CTRL, {28'h0, c}, 4'hF);
            d = (c[0] & c[2]) ? {28'h0, 2'h3, c[1], ~c[1]} : {28'h0, 4'h2 ^ c};
            chk({28'h0, pin_out}, d);
            chk({28'h0, pin_oe_n}, (c[0] & c[2]) ? 32'h2 : {28'h0, 4'hD ^ c});
        end
        // a fresh frame holds far more byte times than the 18 byte threshold
        want <= 1'b1;
        @(posedge core_clk);
        #1 chk({31'h0, tok_start}, 32'h1);
        @(posedge core_clk);
        want <= 1'b0;
        repeat (8) @(posedge core_clk);
        wr(`UST_OFF_CTRL, 32'h5, 4'hF);
        want <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({31'h0, tok_req}, 32'h1);
        wr(`UST_OFF_CTRL, 32'h7, 4'hF);
        chk({31'h0, tok_req}, 32'h0);
        want <= 1'b0;
        repeat (8) @(posedge core_clk);
        // the largest threshold brings the short tail of the frame within reach
        wr(`UST_OFF_SOF_THR, 32'hFF, 4'hF);
        d = 32'h0;
        while (d[15] !== 1'b1) begin
            xfer(1'b0, `UST_OFF_STATUS, 32'h0, 4'hF, d);
        end
        chk({31'h0, d[13:0] < 14'h00FF}, 32'h1);
        want <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({30'h0, tok_req, tok_start}, 32'h2);
        xfer(1'b0, `UST_OFF_STATUS, 32'h0, 4'hF, d);
        chk({30'h0, d[15:14]}, 32'h2);
        // the parked ask is only granted once the next frame starts
        while (tok_req === 1'b1) begin
            @(posedge core_clk);
        end
        want <= 1'b0;
        xfer(1'b0, `UST_OFF_STATUS, 32'h0, 4'hF, d);
        chk({31'h0, d[15]}, 32'h0);
        chk({31'h0, d[13:0] > 14'h0500}, 32'h1);
        repeat (8) @(posedge core_clk);
        wrap_up();
    end
endmodule : usb_sof_threshold_bdt_base_tb
`default_nettype wire
